// ---- logic/gpr_pkg.sv ----
// ------------------------------------------------------------
// register map and port geometry
// ------------------------------------------------------------
package gpr_pkg;
    // bidirectional ports: index 0 = port 1, 1..4 = ports a..d
    localparam int        NPORT       = 5;
    localparam int        PORT_W [5]  = '{8, 4, 8, 8, 8};
    localparam bit        HAS_PU [5]  = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    localparam bit        HAS_OD [5]  = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
    localparam int        P4_W        = 8;
    localparam int        P9_W        = 4;

    localparam int        ADDR_W      = 8;
    localparam logic [7:0] PORT_STRIDE = 8'h20;
    localparam logic [4:0] OFF_DIR     = 5'h00;
    localparam logic [4:0] OFF_LATCH   = 5'h04;
    localparam logic [4:0] OFF_PULLUP  = 5'h08;
    localparam logic [4:0] OFF_ODRAIN  = 5'h0c;
    localparam logic [4:0] OFF_PIN     = 5'h10;
    localparam logic [7:0] ADDR_P4_PIN = 8'ha0;
    localparam logic [7:0] ADDR_P9_PIN = 8'ha4;

    localparam logic [7:0] RST_CTRL    = 8'h00;

    // register selector codes from the address decoder
    localparam logic [2:0] SEL_DIR     = 3'h0;
    localparam logic [2:0] SEL_LATCH   = 3'h1;
    localparam logic [2:0] SEL_PULLUP  = 3'h2;
    localparam logic [2:0] SEL_ODRAIN  = 3'h3;
    localparam logic [2:0] SEL_PIN     = 3'h4;
    localparam logic [2:0] SEL_P4      = 3'h5;
    localparam logic [2:0] SEL_P9      = 3'h6;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ------------------------------------------------------------
// one bidirectional port: control registers and pin drive
// ------------------------------------------------------------
module gpr_port #(
    parameter int W      = 8,
    parameter bit HAS_PU = 1'b1,
    parameter bit HAS_OD = 1'b1
) (
    // clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // register writes
    input  wire logic         wr_dir,
    input  wire logic         wr_latch,
    input  wire logic         wr_pu,
    input  wire logic         wr_od,
    input  wire logic [7:0]   wdata,
    // register contents, zero above W
    output logic      [7:0]   dir_q,
    output logic      [7:0]   latch_q,
    output logic      [7:0]   pu_q,
    output logic      [7:0]   od_q,
    // pins
    output logic      [W-1:0] pin_o,
    output logic      [W-1:0] pin_oe,
    output logic      [W-1:0] pin_pu
);
    logic [W-1:0] dir_r;
    logic [W-1:0] latch_r;
    logic [W-1:0] pu_r;
    logic [W-1:0] od_r;

    if (W < 1 || W > 8) begin : g_bad_w
        $error("gpr_port: width must be 1 to 8");
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dir_r   <= gpr_pkg::RST_CTRL[W-1:0];
            latch_r <= gpr_pkg::RST_CTRL[W-1:0];
            pu_r    <= gpr_pkg::RST_CTRL[W-1:0];
            od_r    <= gpr_pkg::RST_CTRL[W-1:0];
        end else begin
            if (wr_dir) dir_r <= wdata[W-1:0];
            if (wr_latch) latch_r <= wdata[W-1:0];
            if (wr_pu && HAS_PU) pu_r <= wdata[W-1:0];
            if (wr_od && HAS_OD) od_r <= wdata[W-1:0];
        end
    end

    assign dir_q   = 8'(dir_r);
    assign latch_q = 8'(latch_r);
    assign pu_q    = 8'(pu_r);
    assign od_q    = 8'(od_r);

    // open drain: high side off, so a high latch bit releases the pin
    assign pin_o   = latch_r;
    assign pin_oe  = dir_r & ~(od_r & latch_r);
    // pull-up only on inputs; an output never fights its own pull-up
    assign pin_pu  = ~dir_r & pu_r;
endmodule

// ---- logic/gpr_top.sv ----
// Operation
// - each bidirectional pin has a direction bit choosing input or output
// - each bidirectional pin has a writable output latch driving output pins
// - every port reads back the present levels on its pins
// - input-only ports have neither output latch nor direction bit
// - ports a to d have per-pin pull-ups set by a pull-up register
// - ports a to c have per-pin open-drain control of the high-side driver
// - port 1 is an eight-pin bidirectional port shared with other functions
// - ports 4 and 9 are input-only, eight and four pins, analog shared
module gpr_top (
    // clock and reset
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    // axi4-lite write address
    input  wire logic [gpr_pkg::ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    // axi4-lite read address
    input  wire logic [gpr_pkg::ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    // axi4-lite read data
    output logic [31:0]                       s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    // bidirectional pins: [0] port 1, [1..4] ports a..d
    input  wire logic [gpr_pkg::NPORT-1:0][7:0] pin_i,
    output logic      [gpr_pkg::NPORT-1:0][7:0] pin_o,
    output logic      [gpr_pkg::NPORT-1:0][7:0] pin_oe,
    output logic      [gpr_pkg::NPORT-1:0][7:0] pin_pu,
    // input-only pins
    input  wire logic [gpr_pkg::P4_W-1:0]     p4_pin_i,
    input  wire logic [gpr_pkg::P9_W-1:0]     p9_pin_i
);
    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    // result: {valid, port index, selector}
    function automatic logic [6:0] decode(input logic [7:0] addr);
        logic [2:0] port;
        logic [4:0] off;
        port = addr[7:5];
        off  = addr[4:0];
        decode = 7'h00;
        if (addr == gpr_pkg::ADDR_P4_PIN) decode = {1'b1, 3'h0, gpr_pkg::SEL_P4};
        else if (addr == gpr_pkg::ADDR_P9_PIN) decode = {1'b1, 3'h0, gpr_pkg::SEL_P9};
        else if (port < 3'(gpr_pkg::NPORT)) begin
            case (off)
                gpr_pkg::OFF_DIR:    decode = {1'b1, port, gpr_pkg::SEL_DIR};
                gpr_pkg::OFF_LATCH:  decode = {1'b1, port, gpr_pkg::SEL_LATCH};
                gpr_pkg::OFF_PULLUP: begin
                    if (gpr_pkg::HAS_PU[port]) decode = {1'b1, port, gpr_pkg::SEL_PULLUP};
                end
                gpr_pkg::OFF_ODRAIN: begin
                    if (gpr_pkg::HAS_OD[port]) decode = {1'b1, port, gpr_pkg::SEL_ODRAIN};
                end
                gpr_pkg::OFF_PIN:    decode = {1'b1, port, gpr_pkg::SEL_PIN};
                default:             decode = 7'h00;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // write channel
    // ------------------------------------------------------------
    logic       aw_got_r;
    logic       w_got_r;
    logic [7:0] awaddr_r;
    logic [7:0] wdata_r;
    logic       wstrb0_r;
    logic       bvalid_r;
    logic [1:0] bresp_r;

    wire        wr_fire  = aw_got_r && w_got_r && !bvalid_r;
    wire  [6:0] wr_dec   = decode(awaddr_r);
    wire  [2:0] wr_port  = wr_dec[5:3];
    wire  [2:0] wr_sel   = wr_dec[2:0];
    // pin levels are read-only; input-only ports own no writable register
    wire        wr_legal = wr_dec[6] && (wr_sel <= gpr_pkg::SEL_ODRAIN);
    wire        wr_en    = wr_fire && wr_legal && wstrb0_r;

    assign s_axi_awready = !aw_got_r && !bvalid_r;
    assign s_axi_wready  = !w_got_r && !bvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r  <= 8'h00;
            wstrb0_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r  <= gpr_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r  <= 1'b1;
                wdata_r  <= s_axi_wdata[7:0];
                wstrb0_r <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_got_r <= 1'b0;
                w_got_r  <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r  <= wr_legal ? gpr_pkg::RESP_OKAY : gpr_pkg::RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // ports
    // ------------------------------------------------------------
    logic [gpr_pkg::NPORT-1:0][7:0] dir_q;
    logic [gpr_pkg::NPORT-1:0][7:0] latch_q;
    logic [gpr_pkg::NPORT-1:0][7:0] pu_q;
    logic [gpr_pkg::NPORT-1:0][7:0] od_q;
    logic [gpr_pkg::NPORT-1:0][7:0] pin_rb;

    for (genvar p = 0; p < gpr_pkg::NPORT; p++) begin : g_port
        localparam int W = gpr_pkg::PORT_W[p];
        wire hit = wr_en && (wr_port == 3'(p));
        gpr_port #(
            .W      (W),
            .HAS_PU (gpr_pkg::HAS_PU[p]),
            .HAS_OD (gpr_pkg::HAS_OD[p])
        ) u_port (
            .aclk     (aclk),
            .aresetn  (aresetn),
            .wr_dir   (hit && wr_sel == gpr_pkg::SEL_DIR),
            .wr_latch (hit && wr_sel == gpr_pkg::SEL_LATCH),
            .wr_pu    (hit && wr_sel == gpr_pkg::SEL_PULLUP),
            .wr_od    (hit && wr_sel == gpr_pkg::SEL_ODRAIN),
            .wdata    (wdata_r),
            .dir_q    (dir_q[p]),
            .latch_q  (latch_q[p]),
            .pu_q     (pu_q[p]),
            .od_q     (od_q[p]),
            .pin_o    (pin_o[p][W-1:0]),
            .pin_oe   (pin_oe[p][W-1:0]),
            .pin_pu   (pin_pu[p][W-1:0])
        );
        // absent pins read as zero and are never driven
        assign pin_rb[p] = 8'(pin_i[p][W-1:0]);
        if (W < 8) begin : g_pad
            assign pin_o[p][7:W]  = '0;
            assign pin_oe[p][7:W] = '0;
            assign pin_pu[p][7:W] = '0;
        end
    end

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;
    logic [31:0] rd_nxt;

    wire  [6:0]  rd_dec  = decode(s_axi_araddr);
    wire  [2:0]  rd_port = rd_dec[5:3];
    wire         rd_fire = s_axi_arvalid && s_axi_arready;

    always_comb begin
        rd_nxt = 32'h0000_0000;
        case (rd_dec[2:0])
            gpr_pkg::SEL_DIR:    rd_nxt = 32'(dir_q[rd_port]);
            gpr_pkg::SEL_LATCH:  rd_nxt = 32'(latch_q[rd_port]);
            gpr_pkg::SEL_PULLUP: rd_nxt = 32'(pu_q[rd_port]);
            gpr_pkg::SEL_ODRAIN: rd_nxt = 32'(od_q[rd_port]);
            gpr_pkg::SEL_PIN:    rd_nxt = 32'(pin_rb[rd_port]);
            gpr_pkg::SEL_P4:     rd_nxt = 32'(p4_pin_i);
            gpr_pkg::SEL_P9:     rd_nxt = 32'(p9_pin_i);
            default:             rd_nxt = 32'h0000_0000;
        endcase
        if (!rd_dec[6]) rd_nxt = 32'h0000_0000;
    end

    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= gpr_pkg::RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_nxt;
            rresp_r  <= rd_dec[6] ? gpr_pkg::RESP_OKAY : gpr_pkg::RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence wr_to(logic [7:0] a);
        wr_fire && wstrb0_r && awaddr_r == a;
    endsequence

    dir_update_a: assert property (wr_to(gpr_pkg::OFF_DIR) |=>
        dir_q[0] == $past(wdata_r))
        else $error("port 1 direction not updated by write");
    latch_update_a: assert property (wr_to(8'h20 | gpr_pkg::OFF_LATCH) |=>
        latch_q[1] == {4'h0, $past(wdata_r[3:0])} && pin_o[1][3:0] == latch_q[1][3:0])
        else $error("port a latch not updated by write");
    pin_read_a: assert property (rd_fire && s_axi_araddr == 8'(gpr_pkg::OFF_PIN) |=>
        s_axi_rvalid && s_axi_rdata == 32'($past(pin_i[0])))
        else $error("port 1 pin readback wrong");
    input_only_a: assert property (wr_fire && awaddr_r == gpr_pkg::ADDR_P4_PIN |=>
        s_axi_bvalid && s_axi_bresp == gpr_pkg::RESP_SLVERR)
        else $error("write to input-only port accepted");
    pullup_gate_a: assert property (wr_to(8'h20 | gpr_pkg::OFF_PULLUP) |=>
        pin_pu[1][3:0] == ($past(wdata_r[3:0]) & ~dir_q[1][3:0]))
        else $error("port a pull-up not applied");
    odrain_a: assert property (od_q[2][0] && latch_q[2][0] |-> !pin_oe[2][0])
        else $error("open-drain pin drives high");
    port1_pp_a: assert property (pin_oe[0] == dir_q[0] && pu_q[0] == 8'h00)
        else $error("port 1 output enable differs from direction");
    p9_read_a: assert property (rd_fire && s_axi_araddr == gpr_pkg::ADDR_P9_PIN |=>
        s_axi_rdata == 32'($past(p9_pin_i)) && s_axi_rresp == gpr_pkg::RESP_OKAY)
        else $error("port 9 readback wrong");
    pu_out_off_a: assert property (dir_q[3][5] |-> !pin_pu[3][5])
        else $error("pull-up active on output pin");
    bit_align_a: assert property (wr_to(8'h80 | gpr_pkg::OFF_DIR) ##1 s_axi_bvalid |=>
        dir_q[4] == $past(wdata_r, 2))
        else $error("port d direction bits misaligned");
endmodule

// ---- sim/gpr_pin_model.sv ----
// ----------------------------------------------------------------
// board side of the bidirectional pins
// ----------------------------------------------------------------
module gpr_pin_model (
    // clock
    input  wire logic            aclk,
    // drive from the port logic
    input  wire logic [4:0][7:0] pin_o,
    input  wire logic [4:0][7:0] pin_oe,
    input  wire logic [4:0][7:0] pin_pu,
    // external drivers, same pattern on every port
    input  wire logic [7:0]      ext_en,
    input  wire logic [7:0]      ext_val,
    // resolved pin levels
    output logic      [4:0][7:0] pin_lvl
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0][7:0] last_r = '0;
    always_ff @(posedge aclk) begin
        last_r <= pin_lvl;
    end
    // an undriven pin with no pull-up floats: toggle so no stale level reads back
    always_comb begin
        for (int p = 0; p < 5; p++) begin
            for (int b = 0; b < 8; b++) begin
                if (pin_oe[p][b]) begin
                    pin_lvl[p][b] = pin_o[p][b];
                end else if (ext_en[b]) begin
                    pin_lvl[p][b] = ext_val[b];
                end else if (pin_pu[p][b]) begin
                    pin_lvl[p][b] = 1'b1;
                end else begin
                    pin_lvl[p][b] = ~last_r[p][b];
                end
            end
        end
    end
endmodule

// ---- sim/general_purpose_io_ports_bench.sv ----
module general_purpose_io_ports_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr, ext_en, ext_val, p4_pin;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [3:0] p9_pin, wstrb;
    logic [4:0][7:0] pin_i, pin_o, pin_oe, pin_pu;
    int error_cnt = 0;
    int n_checks = 0;
    gpr_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
        .pin_pu(pin_pu), .p4_pin_i(p4_pin), .p9_pin_i(p9_pin));
    gpr_pin_model pins (.aclk(aclk), .pin_o(pin_o), .pin_oe(pin_oe), .pin_pu(pin_pu),
        .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_i));
    // ----------------------------------------------------------------
    // bus cycles and compares
    // ----------------------------------------------------------------
    // ready and answers are read at the rising edge, before that edge's updates land
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
        bit ta, tw;
        @(posedge aclk);
        awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        ta = 0; tw = 0;
        while (!(ta && tw)) begin
            @(posedge aclk);
            if (awready) ta = 1;
            if (wready) tw = 1;
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        do @(posedge aclk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        d = rdata; r = rresp;
        rready <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected resp at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        logic [31:0] d;
        logic [1:0] r;
        for (int p = 0; p < 5; p++) begin
            rd(8'(p * 32), d, r);
            chk(d, 32'h0);
            rd(8'(p * 32 + 4), d, r);
            chk(d, 32'h0);
            chk({pin_o[p], pin_oe[p], pin_pu[p]}, 32'h0);
        end
    endtask
    // low four bits driven, high four from outside: readback mixes both per bit
    task automatic t_drive();
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] m;
        for (int p = 0; p < 5; p++) begin
            m = 8'((1 << gpr_pkg::PORT_W[p]) - 1);
            wr(8'(p * 32 + 4), 8'h5a, r);
            chk_resp(r, gpr_pkg::RESP_OKAY);
            wr(8'(p * 32), 8'h0f, r);
            chk_resp(r, gpr_pkg::RESP_OKAY);
            chk(pin_o[p] & m, 32'(8'h5a & m));
            chk(pin_oe[p] & m, 32'(8'h0f & m));
            rd(8'(p * 32 + 4), d, r);
            chk(d, 32'(8'h5a & m));
            rd(8'(p * 32 + 16), d, r);
            chk(d, 32'((8'h0a | (8'hc3 & 8'hf0)) & m));
        end
    endtask
    task automatic t_pullup();
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] m;
        ext_en <= 8'h00;
        wr(8'h08, 8'hff, r);
        chk_resp(r, gpr_pkg::RESP_SLVERR);
        chk(pin_pu[0], 32'h0);
        for (int p = 1; p < 5; p++) begin
            m = 8'((1 << gpr_pkg::PORT_W[p]) - 1);
            wr(8'(p * 32), 8'h33, r);
            wr(8'(p * 32 + 8), 8'hf5, r);
            chk_resp(r, gpr_pkg::RESP_OKAY);
            chk(pin_pu[p] & m, 32'(8'hc4 & m));
            rd(8'(p * 32 + 16), d, r);
            chk(d & 32'(8'hc4 | 8'h33), 32'((8'hc4 | 8'h12) & m));
        end
    endtask
    task automatic t_odrain();
        logic [1:0] r;
        logic [7:0] m;
        for (int p = 0; p < 5; p++) begin
            m = 8'((1 << gpr_pkg::PORT_W[p]) - 1);
            wr(8'(p * 32), 8'hff, r);
            wr(8'(p * 32 + 12), 8'hff, r);
            chk_resp(r, gpr_pkg::HAS_OD[p] ? gpr_pkg::RESP_OKAY : gpr_pkg::RESP_SLVERR);
            chk(pin_oe[p] & m, 32'((gpr_pkg::HAS_OD[p] ? 8'ha5 : 8'hff) & m));
        end
    endtask
    task automatic t_inonly();
        logic [31:0] d;
        logic [1:0] r;
        p4_pin <= 8'h96;
        p9_pin <= 4'h9;
        rd(gpr_pkg::ADDR_P4_PIN, d, r);
        chk(d, 32'h96);
        rd(gpr_pkg::ADDR_P9_PIN, d, r);
        chk(d, 32'h9);
        wr(gpr_pkg::ADDR_P4_PIN, 8'hff, r);
        chk_resp(r, gpr_pkg::RESP_SLVERR);
        // a write with byte 0 unselected answers okay and stores nothing
        wstrb <= 4'h0;
        wr(8'h04, 8'hff, r);
        chk_resp(r, gpr_pkg::RESP_OKAY);
        wstrb <= 4'h1;
        rd(8'h04, d, r);
        chk(d, 32'h5a);
        rd(8'hf0, d, r);
        chk({d[29:0], r}, {30'h0, gpr_pkg::RESP_SLVERR});
    endtask
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    initial begin
        repeat (5000) @(posedge aclk);
        error_cnt++;
        finish_test();
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        ext_en = 8'hff; ext_val = 8'hc3; p4_pin = 8'h00; p9_pin = 4'h0;
        wstrb = 4'h1;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_drive();
        t_pullup();
        t_odrain();
        t_inonly();
        finish_test();
    end
endmodule
